//--- shared/abx_consts.vh
// constants for the and/branch/bit-clear execute block
`ifndef ABX_CONSTS_VH
`define ABX_CONSTS_VH
`define ABX_OP_ANDLIT_HI     8'h0b
`define ABX_OP_ANDFILE_HI    6'h05
`define ABX_OP_BRC_HI        8'he2
`define ABX_OP_BITCLR_HI     4'h9
`define ABX_ILO_MAX          8'h5f
`define ABX_BIT_D            9
`define ABX_BIT_A            8
`define ABX_STAT_C           0
`define ABX_STAT_DC          1
`define ABX_STAT_Z           2
`define ABX_STAT_OV          3
`define ABX_STAT_N           4
`define ABX_W_RST            8'h00
`define ABX_STAT_RST         5'h00
`define ABX_PC_RST           21'h000000
`define ABX_BSR_RST          4'h0
`define ABX_PC_STEP          21'h000002
`define ABX_REG_CTRL         12'h000
`define ABX_REG_WREG         12'h004
`define ABX_REG_STATUS       12'h008
`define ABX_REG_PC           12'h00c
`define ABX_REG_INSTR        12'h010
`define ABX_REG_BSR          12'h014
`define ABX_REG_ADDR         12'h018
`define ABX_REG_CYCLES       12'h01c
`define ABX_CTRL_EXT         0
`define ABX_CTRL_GO          1
`endif

//--- tb/abx_exec_props.sv
// port assertions for the execute block
`timescale 1ns/10ps
`include "abx_consts.vh"
module abx_exec_props (
  input wire        i_core_clk,
  input wire        i_reset_n,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire        o_pready,
  input wire        o_pslverr,
  input wire [20:0] o_pc,
  input wire [7:0]  o_wreg,
  input wire [4:0]  o_status,
  input wire        o_busy
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  wire wr = i_psel && i_penable && i_pwrite && o_pready;
  idle_ready_a: assert property (!i_psel |-> !o_pready) else $error("ready while idle");
  err_ready_a: assert property (o_pslverr |-> o_pready) else $error("error without ready");
  write_ack_a: assert property (i_psel && i_penable && i_pwrite && !o_busy |-> o_pready)
    else $error("write not acked at once");
  read_wait_a: assert property (i_psel && !i_penable && !i_pwrite ##1 i_penable
    |-> !o_pready ##1 o_pready) else $error("read wait wrong");
  busy_len_a: assert property ($rose(o_busy) |-> ##[1:2] !o_busy) else $error("busy too long");
  pc_even_a: assert property (o_pc[0] == 1'b0) else $error("pc odd");
  go_busy_a: assert property (wr && i_paddr == `ABX_REG_CTRL && i_pwdata[1] && !o_busy
    |=> o_busy) else $error("go ignored");
  wreg_hold_a: assert property (!o_busy && !(wr && i_paddr == `ABX_REG_WREG)
    |=> $stable(o_wreg)) else $error("w moved");
  stat_hold_a: assert property (!o_busy && !(wr && i_paddr == `ABX_REG_STATUS)
    |=> $stable(o_status)) else $error("status moved");
  pc_hold_a: assert property (!o_busy && !(wr && i_paddr == `ABX_REG_PC)
    |=> $stable(o_pc)) else $error("pc moved");
  cover property ($rose(o_busy) ##1 o_busy);
  cover property (o_pslverr);
  cover property (i_psel && !i_pwrite && o_pready);
endmodule
bind abx_exec abx_exec_props abx_exec_props_i (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_pc(o_pc), .o_wreg(o_wreg), .o_status(o_status), .o_busy(o_busy));

//--- tb/abx_exec_tb.sv
// self-checking bench for the execute block
`timescale 1ns/10ps
`include "abx_consts.vh"
module abx_exec_tb;
  logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, seed = 32'h6464;
  logic [7:0]  k, wm, mv, f;
  logic [4:0]  sm;
  logic [20:0] pcm;
  wire  [31:0] prdata;
  wire         pready, perr, busy;
  wire  [20:0] pc;
  wire  [7:0]  wreg;
  wire  [4:0]  stat;
  int          bad_count = 0, compares = 0, cyc = 0, i, n;
  always #25 clk = ~clk;
  abx_exec abx_exec_i (.i_core_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(perr), .o_pc(pc), .o_wreg(wreg), .o_status(stat), .o_busy(busy));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // request held from setup until the edge where pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    n = 0;
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) bad_count++;
    rd = prdata;
    err = perr;
    psel <= 0;
    pen <= 0;
  endtask
  function automatic logic [11:0] ma(input logic [11:0] a);
    return {a[9:0], 2'b00};
  endfunction
  task run(input logic [15:0] op, input logic ext, input logic [31:0] cy);
    apb(1, `ABX_REG_INSTR, {16'h0, op});
    apb(1, `ABX_REG_CTRL, {30'h0, 1'b1, ext});
    n = 0;
    @(negedge clk);
    while (busy !== 1'b0 && n < 8) begin
      n++;
      @(negedge clk);
    end
    if (busy !== 1'b0) bad_count++;
    check(wreg, wm);
    check(stat, sm);
    check(pc, pcm);
    apb(0, `ABX_REG_CYCLES, 0);
    check(rd, cy);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    apb(0, `ABX_REG_PC, 0);
    check(rd, 0);
    apb(0, `ABX_REG_STATUS, 0);
    check(rd, 0);
    apb(0, 12'h020, 0);
    check({rd[30:0], err}, 1); // unmapped
    {wm, sm, pcm} = 0;
    apb(1, `ABX_REG_BSR, 2);
    for (i = 0; i < 24; i++) begin
      k = (i == 0) ? 8'h00 : rnd();
      f = rnd();
      mv = rnd();
      wm = rnd();
      sm = rnd();
      apb(1, `ABX_REG_WREG, wm);
      apb(1, `ABX_REG_STATUS, sm);
      apb(1, ma({4'h2, f}), mv);
      pcm = pcm + 2;
      if (i < 6) begin
        wm = wm & k;
        sm = {wm[7], sm[3], wm == 0, sm[1:0]};
        run({8'h0b, k}, 0, 1);
      end else if (i < 12) begin
        k = wm & mv;
        sm = {k[7], sm[3], k == 0, sm[1:0]};
        if (i[0]) mv = k;
        else wm = k;
        run({6'h05, i[0], 1'b1, f}, 0, 1);
        apb(0, ma({4'h2, f}), 0);
        check(rd, mv);
      end else if (i < 20) begin
        mv[i[2:0]] = 0;
        run({4'h9, i[2:0], 1'b1, f}, 0, 1);
        apb(0, ma({4'h2, f}), 0);
        check(rd, mv);
      end else begin
        apb(1, `ABX_REG_ADDR, 12'h200);
        apb(1, ma(12'h25f), mv);
        mv[i[2:0]] = 0;
        run({4'h9, i[2:0], 1'b0, 8'h5f}, 1, 1);
        apb(0, ma(12'h25f), 0);
        check(rd, mv);
      end
    end
    $display("data ops done");
    for (i = 0; i < 8; i++) begin
      k = (i < 2) ? 8'h80 : (i < 4) ? 8'h7f : rnd();
      sm = {rnd(), i[0]};
      pcm = {rnd(), 1'b0};
      apb(1, `ABX_REG_STATUS, sm);
      apb(1, `ABX_REG_PC, pcm);
      pcm = pcm + 2 + (i[0] ? {{12{k[7]}}, k, 1'b0} : 21'h0);
      run({8'he2, k}, 0, i[0] ? 2 : 1);
    end
    $display("branch done");
    report_and_stop;
  end
endmodule

//--- verilog/abx_decode.v
// opcode decode and data address formation
`timescale 1ns/10ps
`include "abx_consts.vh"
module abx_decode (
  // instruction and bank state
  input  wire [15:0] i_instr,
  input  wire [3:0]  i_bank_select_register,
  input  wire        i_ext_en,
  input  wire [11:0] i_fsr2,
  // decoded class
  output wire        o_and_literal_op,
  output wire        o_and_file_op,
  output wire        o_branch_on_carry_op,
  output wire        o_bit_clear_op,
  output wire        o_dest_file,
  output wire [2:0]  o_bit_idx,
  output wire        o_indexed,
  output wire [11:0] o_addr
);
  wire [7:0] f = i_instr[7:0];
  wire       a = i_instr[`ABX_BIT_A];
  assign o_and_literal_op     = i_instr[15:8] == `ABX_OP_ANDLIT_HI;
  assign o_and_file_op        = i_instr[15:10] == `ABX_OP_ANDFILE_HI;
  assign o_branch_on_carry_op = i_instr[15:8] == `ABX_OP_BRC_HI;
  assign o_bit_clear_op       = i_instr[15:12] == `ABX_OP_BITCLR_HI;
  assign o_dest_file          = i_instr[`ABX_BIT_D];
  assign o_bit_idx            = i_instr[11:9];
  assign o_indexed = i_ext_en & ~a & (f <= `ABX_ILO_MAX);
  // access bank: low half at bank 0, upper half maps to the top page
  assign o_addr = o_indexed ? i_fsr2 + {4'h0, f} :
                  a ? {i_bank_select_register, f} :
                  (f[7] ? {4'hf, f} : {4'h0, f});
endmodule

//--- verilog/abx_exec.v
// execute unit for and-literal, and-file, branch-on-carry, bit-clear with apb access
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "abx_consts.vh"
// How it works
// - literal and: w and 8-bit immediate, result written to w
// - both and forms change only the negative and zero flags
// - file and: w anded with the addressed file register
// - destination bit 0 writes w, 1 writes the file register
// - bank bit 0 picks access bank, 1 uses bank select register
// - extended set, bank bit 0, address at most 95: indexed offset
// - branch on carry decoded from e2, signed offset, no flag change
// - branch taken only when carry is 1, else fall through
// - taken: pc = pc + 2 + 2n, two cycles, second is a no-op
// - offset doubled as two's complement, targets stay word aligned
// - bit clear zeroes chosen bit by read-modify-write, flags untouched
module abx_exec (
  // clock and reset
  input  wire        i_core_clk,
  input  wire        i_reset_n,
  // apb slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire        o_pready,
  output wire        o_pslverr,
  // core state
  output reg  [20:0] o_pc,
  output reg  [7:0]  o_wreg,
  output reg  [4:0]  o_status,
  output wire        o_busy
);
  localparam ST_IDLE = 3'b001;
  localparam ST_EXEC = 3'b010;
  localparam ST_NOP  = 3'b100;

  reg  [2:0]  state_q, state_d;
  reg  [15:0] instr_q;
  reg  [3:0]  bsr_q;
  reg  [11:0] fsr2_q;
  reg         ext_q;
  reg  [15:0] cycles_q;
  reg  [31:0] prdata_q;
  reg         rd_done_q;

  wire        is_andl, is_andf, is_brc, is_bclr, dest_f, indexed;
  wire [2:0]  bit_idx;
  wire [11:0] daddr;
  wire [7:0]  fdata;

  abx_decode u_dec (
    .i_instr                (instr_q),
    .i_bank_select_register (bsr_q),
    .i_ext_en               (ext_q),
    .i_fsr2                 (fsr2_q),
    .o_and_literal_op       (is_andl),
    .o_and_file_op          (is_andf),
    .o_branch_on_carry_op   (is_brc),
    .o_bit_clear_op         (is_bclr),
    .o_dest_file            (dest_f),
    .o_bit_idx              (bit_idx),
    .o_indexed              (indexed),
    .o_addr                 (daddr)
  );

  // apb decode
  wire acc  = i_psel & i_penable;
  wire wr   = acc & i_pwrite;
  wire mapped = (i_paddr[11:5] == 7'h00) & (i_paddr[1:0] == 2'b00);
  // memory window sits at 0x800..0xfff, word per byte of data memory
  wire mem_hit = i_paddr[11];
  wire exec_now = state_q == ST_EXEC;
  wire mem_wr_bus = wr & mem_hit & ~exec_now;

  wire [7:0] and_lit  = o_wreg & instr_q[7:0];
  wire [7:0] and_file = o_wreg & fdata;
  wire [7:0] and_res  = is_andl ? and_lit : and_file;
  wire [7:0] bclr_res = fdata & ~(8'h01 << bit_idx);

  wire        ex_mem_we = exec_now & ((is_andf & dest_f) | is_bclr);
  wire [7:0]  ex_mem_wd = is_bclr ? bclr_res : and_file;
  wire        carry     = o_status[`ABX_STAT_C];
  wire        taken     = exec_now & is_brc & carry;

  // doubled sign-extended offset
  function [20:0] brc_target;
    input [20:0] pc;
    input [7:0]  n;
    begin
      brc_target = pc + `ABX_PC_STEP + {{12{n[7]}}, n, 1'b0};
    end
  endfunction

  // bus reads of memory go through the same read port when idle
  wire [11:0] raddr = exec_now ? daddr : {2'b00, i_paddr[11:2]};

  abx_regfile #(.AW(12)) u_mem (
    .i_core_clk (i_core_clk),
    .i_raddr    (raddr),
    .o_rdata    (fdata),
    .i_we       (ex_mem_we | mem_wr_bus),
    .i_waddr    (ex_mem_we ? daddr : {2'b00, i_paddr[11:2]}),
    .i_wdata    (ex_mem_we ? ex_mem_wd : i_pwdata[7:0])
  );

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (wr & mapped & (i_paddr == `ABX_REG_CTRL) & i_pwdata[`ABX_CTRL_GO]) begin
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_d = taken ? ST_NOP : ST_IDLE;
      end
      ST_NOP: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      state_q  <= ST_IDLE;
      instr_q  <= 16'h0000;
      bsr_q    <= `ABX_BSR_RST;
      fsr2_q   <= 12'h000;
      ext_q    <= 1'b0;
      cycles_q <= 16'h0000;
      o_pc     <= `ABX_PC_RST;
      o_wreg   <= `ABX_W_RST;
      o_status <= `ABX_STAT_RST;
    end else begin
      state_q <= state_d;
      if (state_q != ST_IDLE) begin
        cycles_q <= cycles_q + 16'h0001;
      end
      if (exec_now) begin
        if (is_andl | (is_andf & ~dest_f)) begin
          o_wreg <= and_res;
        end
        if (is_andl | is_andf) begin
          o_status[`ABX_STAT_N] <= and_res[7];
          o_status[`ABX_STAT_Z] <= and_res == 8'h00;
        end
        if (taken) begin
          o_pc <= brc_target(o_pc, instr_q[7:0]);
        end else begin
          o_pc <= o_pc + `ABX_PC_STEP;
        end
      end else if (state_q == ST_IDLE && wr && mapped) begin
        case (i_paddr)
          `ABX_REG_CTRL: begin
            ext_q <= i_pwdata[`ABX_CTRL_EXT];
            if (i_pwdata[`ABX_CTRL_GO]) begin
              cycles_q <= 16'h0000;
            end
          end
          `ABX_REG_WREG:   o_wreg   <= i_pwdata[7:0];
          `ABX_REG_STATUS: o_status <= i_pwdata[4:0];
          `ABX_REG_PC:     o_pc     <= {i_pwdata[20:1], 1'b0};
          `ABX_REG_INSTR:  instr_q  <= i_pwdata[15:0];
          `ABX_REG_BSR:    bsr_q    <= i_pwdata[3:0];
          `ABX_REG_ADDR:   fsr2_q   <= i_pwdata[11:0];
          default: begin
          end
        endcase
      end
    end
  end

  // reads take one wait state so memory data is registered
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    if (mem_hit) begin
      rd_mux = {24'h000000, fdata};
    end else if (mapped) begin
      case (i_paddr)
        `ABX_REG_CTRL:   rd_mux = {29'h0, o_busy, 1'b0, ext_q};
        `ABX_REG_WREG:   rd_mux = {24'h0, o_wreg};
        `ABX_REG_STATUS: rd_mux = {27'h0, o_status};
        `ABX_REG_PC:     rd_mux = {11'h0, o_pc};
        `ABX_REG_INSTR:  rd_mux = {16'h0, instr_q};
        `ABX_REG_BSR:    rd_mux = {28'h0, bsr_q};
        `ABX_REG_ADDR:   rd_mux = {20'h0, fsr2_q};
        `ABX_REG_CYCLES: rd_mux = {16'h0, cycles_q};
        default:         rd_mux = 32'h00000000;
      endcase
    end
  end

  always @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      prdata_q  <= 32'h00000000;
      rd_done_q <= 1'b0;
    end else begin
      rd_done_q <= acc & ~i_pwrite & ~rd_done_q & ~exec_now;
      if (acc & ~i_pwrite & ~exec_now) begin
        prdata_q <= rd_mux;
      end
    end
  end

  assign o_busy    = state_q != ST_IDLE;
  // writes complete in the access cycle unless an instruction owns the memory port
  assign o_pready  = i_pwrite ? (acc & ~exec_now) : rd_done_q;
  assign o_pslverr = o_pready & ~mapped & ~mem_hit;
  assign o_prdata  = prdata_q;
endmodule

//--- verilog/abx_regfile.v
// data memory array with one read and one write port
`timescale 1ns/10ps
module abx_regfile #(
  parameter AW = 12
) (
  // clock
  input  wire          i_core_clk,
  // ports
  input  wire [AW-1:0] i_raddr,
  output wire [7:0]    o_rdata,
  input  wire          i_we,
  input  wire [AW-1:0] i_waddr,
  input  wire [7:0]    i_wdata
);
  reg [7:0] mem [0:(1<<AW)-1];
  assign o_rdata = mem[i_raddr];
  always @(posedge i_core_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end
endmodule
